// ### rtl/sdc_stepper_drive_config.sv
/*
 Four-axis stepper drive configuration with emergency shutdown,
 fault query, interrupt and APB register access.
 Assumes an APB master on the same clock; one sample per clock cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module sdc_stepper_drive_config
  import sdc_pkg::*;
(
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [ADDR_W-1:0]             paddr_in,
  input  wire logic [31:0]                   pwdata_in,
  output logic                               pready_out,
  output logic      [31:0]                   prdata_out,
  output logic                               pslverr_out,
  input  wire logic                          emergency_shutdown_input_in,
  input  wire logic                          program_running_in,
  input  wire logic [AXES-1:0]               motion_in,
  input  wire logic [AXES-1:0]               ref_moving_in,
  input  wire logic [AXES-1:0]               step_in,
  output logic      [AXES-1:0][MA_W-1:0]     current_ma_out,
  output logic      [AXES-1:0]               amp_enable_out,
  output logic      [AXES-1:0][MSTEP_W-1:0]  microstep_out,
  output logic      [AXES-1:0]               step_out,
  output logic                               fault_handler_start_out,
  output logic                               irq_out
);
  // ****************************************
  // Declarations
  // ****************************************
  logic                        estop_s1_ff;
  logic                        estop_s2_ff;
  logic                        estop_s3_ff;
  logic                        estop_rise;
  logic                        hi_variant_ff;
  logic                        drive_on_ff;
  logic                        shutdown_ff;
  logic                        off_seen_ff;
  logic [1:0]                  fclass_ff;
  logic [INT_W-1:0]            istat_ff;
  logic [INT_W-1:0]            imask_ff;
  logic [INT_W-1:0]            int_evt;
  logic                        acc;
  logic                        ld;
  logic                        fire;
  logic                        wr_fire;
  logic                        rd_fire;
  logic                        mapped;
  logic                        axis_page;
  logic [1:0]                  axis_sel;
  logic                        cmd_off;
  logic                        cmd_on;
  logic [7:0]                  fault_code;
  logic [31:0]                 nxt_rdata;
  logic [AXES-1:0]             wr_cur;
  logic [AXES-1:0]             wr_hold;
  logic [AXES-1:0]             wr_res;
  logic [AXES-1:0][1:0]        cur_code;
  logic [AXES-1:0][HOLD_W-1:0] hold_val;
  logic [AXES-1:0][RCODE_W-1:0] res_code;
  logic [AXES-1:0]             resting;
  logic [AXES-1:0]             bad_code;
  logic [AXES-1:0]             idle_off;

  // ****************************************
  // Shutdown input synchroniser
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      estop_s1_ff <= 1'b0;
      estop_s2_ff <= 1'b0;
      estop_s3_ff <= 1'b0;
    end else begin
      estop_s1_ff <= emergency_shutdown_input_in;
      estop_s2_ff <= estop_s1_ff;
      estop_s3_ff <= estop_s2_ff;
    end
  end
  assign estop_rise = estop_s2_ff & ~estop_s3_ff;

  // ****************************************
  // APB decode
  // ****************************************
  assign acc       = psel_in & penable_in;
  assign ld        = acc & ~pready_out;
  assign fire      = acc & pready_out;
  assign wr_fire   = fire & pwrite_in;
  assign rd_fire   = fire & ~pwrite_in;
  assign axis_sel  = paddr_in[3:2];
  assign axis_page = (paddr_in[7:4] == PAGE_CUR) ||
                     (paddr_in[7:4] == PAGE_HOLD) ||
                     (paddr_in[7:4] == PAGE_RES);
  assign mapped    = (paddr_in[1:0] == 2'b00) &&
                     (axis_page || paddr_in <= OFS_IMASK);
  assign cmd_off   = wr_fire && paddr_in == OFS_CMD &&
                     pwdata_in[CMD_OFF_BIT];
  assign cmd_on    = wr_fire && paddr_in == OFS_CMD &&
                     pwdata_in[CMD_ON_BIT] && !pwdata_in[CMD_OFF_BIT];

  always_comb begin
    for (int i = 0; i < AXES; i++) begin
      wr_cur[i]  = wr_fire && paddr_in[7:4] == PAGE_CUR &&
                   axis_sel == i[1:0] && paddr_in[1:0] == 2'b00;
      wr_hold[i] = wr_fire && paddr_in[7:4] == PAGE_HOLD &&
                   axis_sel == i[1:0] && paddr_in[1:0] == 2'b00;
      wr_res[i]  = wr_fire && paddr_in[7:4] == PAGE_RES &&
                   axis_sel == i[1:0] && paddr_in[1:0] == 2'b00;
    end
  end

  // Shutdown class reports 3 while tripped; other classes have no source
  assign fault_code = (fclass_ff == FCLASS_ESTOP && estop_s2_ff) ?
                      FCODE_ESTOP : 8'h00;

  always_comb begin
    nxt_rdata = 32'h0;
    if (axis_page) begin
      case (paddr_in[7:4])
        PAGE_CUR:  nxt_rdata = {30'h0, cur_code[axis_sel]};
        PAGE_HOLD: nxt_rdata = {17'h0, hold_val[axis_sel]};
        PAGE_RES:  nxt_rdata = {27'h0, res_code[axis_sel]};
        default:   nxt_rdata = 32'h0;
      endcase
    end else begin
      case (paddr_in)
        OFS_CTRL:   nxt_rdata = {31'h0, hi_variant_ff};
        OFS_FCLASS: nxt_rdata = {30'h0, fclass_ff};
        OFS_FRES:   nxt_rdata = {24'h0, fault_code};
        OFS_STAT:   nxt_rdata = {20'h0, resting, amp_enable_out,
                                 off_seen_ff, estop_s2_ff,
                                 shutdown_ff, drive_on_ff};
        OFS_ISTAT:  nxt_rdata = {29'h0, istat_ff};
        OFS_IMASK:  nxt_rdata = {29'h0, imask_ff};
        default:    nxt_rdata = 32'h0;
      endcase
    end
  end

  // ****************************************
  // APB answer: one wait state
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= ld;
      pslverr_out <= ld & ~mapped;
      if (ld && !pwrite_in) begin
        prdata_out <= mapped ? nxt_rdata : 32'h0;
      end
    end
  end

  // ****************************************
  // Software settings
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      hi_variant_ff <= 1'b0;
      fclass_ff     <= 2'h0;
      imask_ff      <= '0;
    end else if (wr_fire) begin
      if (paddr_in == OFS_CTRL) begin
        hi_variant_ff <= pwdata_in[0];
      end
      if (paddr_in == OFS_FCLASS) begin
        fclass_ff <= pwdata_in[1:0];
      end
      if (paddr_in == OFS_IMASK) begin
        imask_ff <= pwdata_in[INT_W-1:0];
      end
    end
  end

  // ****************************************
  // Drive enable and shutdown recovery
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      drive_on_ff <= 1'b1;
      shutdown_ff <= 1'b0;
      off_seen_ff <= 1'b0;
    end else begin
      if (estop_rise) begin
        drive_on_ff <= 1'b0;
        shutdown_ff <= 1'b1;
        off_seen_ff <= 1'b0;
      end else if (cmd_off) begin
        drive_on_ff <= 1'b0;
        off_seen_ff <= shutdown_ff;
      end else if (cmd_on && !estop_s2_ff &&
                   (!shutdown_ff || off_seen_ff)) begin
        drive_on_ff <= 1'b1;
        shutdown_ff <= 1'b0;
        off_seen_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Fault handler start and interrupts
  // ****************************************
  assign int_evt = {(|idle_off), (|bad_code), estop_rise};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      fault_handler_start_out <= 1'b0;
      istat_ff                <= '0;
      irq_out                 <= 1'b0;
    end else begin
      fault_handler_start_out <= estop_rise & program_running_in;
      if (rd_fire && paddr_in == OFS_ISTAT) begin
        istat_ff <= (istat_ff & ~prdata_out[INT_W-1:0]) | int_evt;
      end else begin
        istat_ff <= istat_ff | int_evt;
      end
      irq_out <= |(istat_ff & imask_ff);
    end
  end

  // ****************************************
  // Axes
  // ****************************************
  for (genvar g = 0; g < AXES; g++) begin : g_axis
    sdc_axis u_axis (
      .sys_clk_in     (sys_clk_in),
      .reset_in       (reset_in),
      .wr_cur_in      (wr_cur[g]),
      .wr_hold_in     (wr_hold[g]),
      .wr_res_in      (wr_res[g]),
      .wdata_in       (pwdata_in),
      .hi_current_in  (hi_variant_ff),
      .drive_on_in    (drive_on_ff),
      .motion_in      (motion_in[g]),
      .ref_moving_in  (ref_moving_in[g]),
      .step_in        (step_in[g]),
      .cur_code_out   (cur_code[g]),
      .hold_out       (hold_val[g]),
      .res_code_out   (res_code[g]),
      .microstep_out  (microstep_out[g]),
      .current_ma_out (current_ma_out[g]),
      .amp_en_out     (amp_enable_out[g]),
      .step_out       (step_out[g]),
      .resting_out    (resting[g]),
      .bad_code_out   (bad_code[g]),
      .idle_off_out   (idle_off[g])
    );
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_trip;
    $rose(estop_s2_ff);
  endsequence
  sequence s_off_after;
    ##2 (amp_enable_out == '0);
  endsequence

  chk_reset_code: assert property (
    $fell(reset_in) |-> cur_code[0] == CUR_RESET)
    else $error("current code not at reset value");
  chk_trip_kills_amps: assert property (
    s_trip |-> s_off_after)
    else $error("amplifiers still enabled after shutdown");
  chk_fault_code_three: assert property (
    ld && !pwrite_in && paddr_in == OFS_FRES &&
    fclass_ff == FCLASS_ESTOP && estop_s2_ff |=> prdata_out == 32'h3)
    else $error("shutdown class did not return 3");
  chk_handler_cause: assert property (
    fault_handler_start_out |-> $past(estop_rise))
    else $error("handler started without a trip");
  chk_recover_order: assert property (
    shutdown_ff && !off_seen_ff && !cmd_off |=> shutdown_ff)
    else $error("shutdown left without drive-off first");
  chk_quarter_hold: assert property (
    drive_on_ff && resting[2] && hold_val[2] == HOLD_LOW |=>
    current_ma_out[2] ==
      (sdc_peak_ma($past(hi_variant_ff), $past(cur_code[2])) >> QUART_SHIFT))
    else $error("hold current not a quarter of peak");
  chk_full_on_move: assert property (
    drive_on_ff && motion_in[0] && !wr_cur[0] && !wr_fire |=>
    current_ma_out[0] == sdc_peak_ma(hi_variant_ff, cur_code[0]))
    else $error("full current not restored for motion");
  chk_step_full: assert property (
    step_in[0] && motion_in[0] && !wr_fire ##1 motion_in[0] && !wr_fire
    |=> !step_out[0] ||
        current_ma_out[0] == sdc_peak_ma(hi_variant_ff, cur_code[0]))
    else $error("step issued before full current");
  chk_hold_alone: assert property (
    wr_hold[0] |=> $stable(hold_val[1]) && $stable(hold_val[2]) &&
                   $stable(hold_val[3]))
    else $error("hold write changed another axis");
  chk_bad_ignored: assert property (
    wr_cur[0] && pwdata_in > 32'h3 |=> $stable(cur_code[0]))
    else $error("illegal current code accepted");
  chk_fixed_mstep: assert property (
    hi_variant_ff && $past(hi_variant_ff) |->
    microstep_out[1] == MSTEP_FIXED)
    else $error("high-current variant not at fixed microstep");
  chk_idle_drop: assert property (
    idle_off[0] |-> $past(hold_val[0]) >= HOLD_TIMED && $past(resting[0]))
    else $error("idle drop without timed hold mode");
  chk_fault_class_zero: assert property (
    ld && !pwrite_in && paddr_in == OFS_FRES && fclass_ff != FCLASS_ESTOP
    |=> prdata_out == 32'h0)
    else $error("non-shutdown fault class not zero");
  chk_query_quiet: assert property (
    rd_fire && paddr_in == OFS_FRES && !estop_rise |=>
    !fault_handler_start_out)
    else $error("fault query started the handler");
  chk_enable_held: assert property (
    shutdown_ff && !off_seen_ff |=> !drive_on_ff)
    else $error("drive enabled before drive-off");
endmodule
`default_nettype wire

// ### rtl/sdc_pkg.sv
/*
 Constants, register map and current table for the stepper drive
 configuration block. Assumes one controller sample per clock cycle.
*/
package sdc_pkg;
  localparam int          AXES       = 4;
  localparam int          ADDR_W     = 8;
  localparam int          MA_W       = 12;
  localparam int          HOLD_W     = 15;
  localparam int          RCODE_W    = 5;
  localparam int          MSTEP_W    = 7;
  // ****************************************
  // Register byte offsets and axis page numbers
  // ****************************************
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_CMD    = 8'h04;
  localparam logic [7:0]  OFS_FCLASS = 8'h08;
  localparam logic [7:0]  OFS_FRES   = 8'h0c;
  localparam logic [7:0]  OFS_STAT   = 8'h10;
  localparam logic [7:0]  OFS_ISTAT  = 8'h14;
  localparam logic [7:0]  OFS_IMASK  = 8'h18;
  localparam logic [3:0]  PAGE_CUR   = 4'h2;
  localparam logic [3:0]  PAGE_HOLD  = 4'h3;
  localparam logic [3:0]  PAGE_RES   = 4'h4;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int          CMD_OFF_BIT = 0;
  localparam int          CMD_ON_BIT  = 1;
  localparam int          INT_ESTOP   = 0;
  localparam int          INT_BADCODE = 1;
  localparam int          INT_IDLE    = 2;
  localparam int          INT_W       = 3;
  localparam logic [1:0]  CUR_RESET   = 2'h1;
  localparam logic [14:0] HOLD_FULL   = 15'h0000;
  localparam logic [14:0] HOLD_LOW    = 15'h0001;
  localparam logic [14:0] HOLD_TIMED  = 15'h0002;
  localparam logic [4:0]  RES_FULL    = 5'h01;
  localparam logic [4:0]  RES_HALF    = 5'h02;
  localparam logic [4:0]  RES_QUART   = 5'h04;
  localparam logic [4:0]  RES_SIXT    = 5'h10;
  localparam logic [6:0]  MSTEP_FIXED = 7'h40;
  localparam int          QUART_SHIFT = 2;
  localparam logic [1:0]  FCLASS_ESTOP = 2'h3;
  localparam logic [7:0]  FCODE_ESTOP  = 8'h03;

  // Peak current in mA for a variant and a current code
  function automatic logic [11:0] sdc_peak_ma(input logic hi,
                                              input logic [1:0] code);
    case (code)
      2'h0:    sdc_peak_ma = 12'h1f4;
      2'h1:    sdc_peak_ma = hi ? 12'h3e8 : 12'h2ee;
      2'h2:    sdc_peak_ma = hi ? 12'h7d0 : 12'h3e8;
      default: sdc_peak_ma = hi ? 12'hbb8 : 12'h578;
    endcase
  endfunction
endpackage

// ### rtl/sdc_axis.sv
/*
 One axis of the stepper drive: current, hold and resolution settings,
 resting detection, idle amplifier timer and step gating.
 Assumes profiler, reference and step inputs come from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module sdc_axis
  import sdc_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               reset_in,
  input  wire logic               wr_cur_in,
  input  wire logic               wr_hold_in,
  input  wire logic               wr_res_in,
  input  wire logic [31:0]        wdata_in,
  input  wire logic               hi_current_in,
  input  wire logic               drive_on_in,
  input  wire logic               motion_in,
  input  wire logic               ref_moving_in,
  input  wire logic               step_in,
  output logic      [1:0]         cur_code_out,
  output logic      [HOLD_W-1:0]  hold_out,
  output logic      [RCODE_W-1:0] res_code_out,
  output logic      [MSTEP_W-1:0] microstep_out,
  output logic      [MA_W-1:0]    current_ma_out,
  output logic                    amp_en_out,
  output logic                    step_out,
  output logic                    resting_out,
  output logic                    bad_code_out,
  output logic                    idle_off_out
);
  logic              cur_ok;
  logic              res_ok;
  logic              resting;
  logic              timed;
  logic              idle_ff;
  logic              step_p1_ff;
  logic [HOLD_W-1:0] cnt_ff;
  logic [MA_W-1:0]   peak;

  assign resting = ~motion_in & ~ref_moving_in;
  assign cur_ok  = (wdata_in[31:2] == 30'h0);
  assign res_ok  = (wdata_in[31:5] == 27'h0) &&
                   (wdata_in[4:0] == RES_FULL || wdata_in[4:0] == RES_HALF ||
                    wdata_in[4:0] == RES_QUART || wdata_in[4:0] == RES_SIXT);
  assign timed   = (hold_out >= HOLD_TIMED);
  assign peak    = sdc_peak_ma(hi_current_in, cur_code_out);
  assign resting_out = resting;

  // ****************************************
  // Settings
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cur_code_out <= CUR_RESET;
      hold_out     <= HOLD_FULL;
      res_code_out <= RES_FULL;
      bad_code_out <= 1'b0;
    end else begin
      if (wr_cur_in && cur_ok) begin
        cur_code_out <= wdata_in[1:0];
      end
      if (wr_hold_in) begin
        hold_out <= wdata_in[HOLD_W-1:0];
      end
      if (wr_res_in && res_ok) begin
        res_code_out <= wdata_in[RCODE_W-1:0];
      end
      bad_code_out <= (wr_cur_in & ~cur_ok) | (wr_res_in & ~res_ok);
    end
  end

  // ****************************************
  // Idle amplifier timer
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt_ff       <= '0;
      idle_ff      <= 1'b0;
      idle_off_out <= 1'b0;
    end else begin
      idle_off_out <= 1'b0;
      if (!resting || !timed) begin
        cnt_ff  <= '0;
        idle_ff <= 1'b0;
      end else if (!idle_ff) begin
        if (cnt_ff == hold_out) begin
          idle_ff      <= 1'b1;
          idle_off_out <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 15'h0001;
        end
      end
    end
  end

  // ****************************************
  // Current, enable and step outputs
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      current_ma_out <= '0;
      amp_en_out     <= 1'b0;
      step_p1_ff     <= 1'b0;
      step_out       <= 1'b0;
      microstep_out  <= '0;
    end else begin
      if (!drive_on_in) begin
        current_ma_out <= '0;
      end else if (resting && hold_out == HOLD_LOW) begin
        current_ma_out <= peak >> QUART_SHIFT;
      end else begin
        current_ma_out <= peak;
      end
      amp_en_out    <= drive_on_in & ~(idle_ff & resting);
      step_p1_ff    <= step_in;
      step_out      <= step_p1_ff & amp_en_out;
      microstep_out <= hi_current_in ? MSTEP_FIXED
                                     : {2'b00, res_code_out};
    end
  end
endmodule
`default_nettype wire

// ### verification/sdc_profiler_model.sv
/*
 Profiler and motor-side model: motion, reference and step per axis.
 Assumes the block's clock and synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module sdc_profiler_model
  import sdc_pkg::*;
(
  input  wire logic            sys_clk_in,
  input  wire logic            reset_in,
  input  wire logic [AXES-1:0] move_in,
  output logic      [AXES-1:0] motion_out,
  output logic      [AXES-1:0] ref_moving_out,
  output logic      [AXES-1:0] step_out
);
  logic [4:0] div_ff;
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      div_ff         <= 5'h00;
      motion_out     <= '0;
      ref_moving_out <= '0;
      step_out       <= '0;
    end else begin
      div_ff         <= div_ff + 5'h01;
      motion_out     <= move_in;
      ref_moving_out <= move_in;
      // One step in 32 cycles
      step_out       <= (div_ff == 5'h1f) ? motion_out : '0;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_stepper_drive_config.sv
/*
 Self-checking bench for the drive configuration block.
 Assumes the profiler model and a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_stepper_drive_config;
  import sdc_pkg::*;
  logic                     clk, rst, psel, pen, pwr, estop, err, prun;
  logic                     pready, pslverr, hstart, irq;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [AXES-1:0]          move, motion, refmv, step, amp, step_o;
  logic [AXES-1:0][MA_W-1:0]    ma;
  logic [AXES-1:0][MSTEP_W-1:0] ms;
  logic [1:0]               code [AXES];
  int                       bad_count, total_checks, hcount, n, a;
  sdc_stepper_drive_config u_dut (.sys_clk_in(clk), .reset_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .emergency_shutdown_input_in(estop),
    .program_running_in(prun), .motion_in(motion), .ref_moving_in(refmv),
    .step_in(step), .current_ma_out(ma), .amp_enable_out(amp),
    .microstep_out(ms), .step_out(step_o),
    .fault_handler_start_out(hstart), .irq_out(irq));
  sdc_profiler_model u_prof (.sys_clk_in(clk), .reset_in(rst),
    .move_in(move), .motion_out(motion), .ref_moving_out(refmv),
    .step_out(step));
  // ****************************************
  // Tasks and expectations
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic apb(input int w, input logic [7:0] ad,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= 1'(w);
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  function automatic logic [31:0] peak(input int hi, input logic [1:0] c);
    case (c)
      2'h0:    peak = 32'h1f4;
      2'h1:    peak = hi ? 32'h3e8 : 32'h2ee;
      2'h2:    peak = hi ? 32'h7d0 : 32'h3e8;
      default: peak = hi ? 32'hbb8 : 32'h578;
    endcase
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (hstart === 1'b1) hcount++;
  end
  initial begin
    idle(20000);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata, move, estop} = '0;
    {rst, prun} = 2'b11;
    code = '{2'h1, 2'h1, 2'h1, 2'h1};
    n = $urandom(89412);
    idle(16);
    rst <= 1'b0;
    idle(4);
    apb(0, 8'h20, 0);
    chk("cur code", 32'h1, rd);
    chk("reset ma", 32'h2ee, 32'(ma[0]));
    chk("reset mstep", 32'h1, 32'(ms[1]));
    for (int hi = 0; hi < 2; hi++) begin
      apb(1, OFS_CTRL, 32'(hi));
      for (int c = 0; c < 4; c++) begin
        a = $urandom % AXES;
        code[a] = 2'(c);
        apb(1, 8'h20 + 8'(4 * a), 32'(c));
        idle(3);
        chk("ma", peak(hi, code[a]), 32'(ma[a]));
      end
      chk("mstep", hi ? 32'h40 : 32'h1, 32'(ms[3]));
    end
    apb(1, OFS_CTRL, 0);
    apb(1, OFS_IMASK, 2);
    for (int r = 0; r < 4; r++) begin
      a = $urandom % AXES;
      apb(1, 8'h40 + 8'(4 * a), 32'h1 << (r + r / 3));
      idle(3);
      chk("res", 32'h1 << (r + r / 3), 32'(ms[a]));
    end
    apb(1, 8'h40 + 8'(4 * a), 3);
    apb(1, 8'h20 + 8'(4 * a), 4);
    apb(0, 8'h20 + 8'(4 * a), 0);
    chk("bad cur", 32'(code[a]), rd);
    chk("bad res", 32'h10, 32'(ms[a]));
    chk("irq", 32'h1, 32'(irq));
    apb(0, OFS_ISTAT, 0);
    chk("istat", 32'h2, rd);
    idle(2);
    chk("irq clr", 32'h0, 32'(irq));
    apb(1, OFS_IMASK, 0);
    apb(1, 8'h40, 7);
    apb(1, 8'h20, 7);
    apb(0, 8'h20, 0);
    chk("bad cur0", 32'(code[0]), rd);
    idle(2);
    chk("irq mask", 32'h0, 32'(irq));
    apb(1, 8'h38, 1);
    idle(3);
    chk("hold ma", peak(0, code[2]) >> 2, 32'(ma[2]));
    move[2] <= 1'b1;
    n = 0;
    while (step_o[2] !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("step", 32'h1, 32'(step_o[2]));
    chk("move ma", peak(0, code[2]), 32'(ma[2]));
    move[2] <= 1'b0;
    idle(6);
    chk("rest ma", peak(0, code[2]) >> 2, 32'(ma[2]));
    apb(1, 8'h30, 5);
    move[0] <= 1'b1;
    idle(20);
    move[0] <= 1'b0;
    idle(5);
    chk("amp hold", 32'h1, 32'(amp[0]));
    n = 0;
    while (amp[0] !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("amp idle", 32'h2, 32'(amp[1:0]));
    move[0] <= 1'b1;
    idle(4);
    chk("amp back", 32'h1, 32'(amp[0]));
    move[0] <= 1'b0;
    apb(1, 8'h30, 0);
    apb(0, 8'hfc, 0);
    chk("unmapped", 32'h1, 32'(err));
    apb(1, OFS_FCLASS, 3);
    n = hcount;
    estop <= 1'b1;
    idle(8);
    chk("estop amp", 32'h0, 32'(amp));
    chk("estop ma", 32'h0, 32'(ma[1]));
    apb(0, OFS_FRES, 0);
    chk("fault", 32'h3, rd);
    chk("handler", 32'(n + 1), 32'(hcount));
    apb(1, OFS_FCLASS, 0);
    apb(0, OFS_FRES, 0);
    chk("class0", 32'h0, rd);
    estop <= 1'b0;
    idle(4);
    apb(1, OFS_CMD, 2);
    idle(4);
    chk("on alone", 32'h0, 32'(amp));
    apb(1, OFS_CMD, 1);
    apb(1, OFS_CMD, 2);
    idle(4);
    chk("recover", 32'hf, 32'(amp));
    prun  <= 1'b0;
    n = hcount;
    estop <= 1'b1;
    idle(8);
    chk("quiet handler", 32'(n), 32'(hcount));
    chk("trip2 amp", 32'h0, 32'(amp));
    estop <= 1'b0;
    rst   <= 1'b1;
    idle(4);
    rst   <= 1'b0;
    idle(4);
    chk("reset recover", 32'hf, 32'(amp));
    tally_and_finish;
  end
endmodule
`default_nettype wire
